// >>> verilog/pol_protection_manager.sv
`timescale 1ns/10ps
`include "pol_cfg.svh"
module pol_protection_manager #(
    parameter int unsigned CYC_PER_MS = `CYC_PER_MS
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    input wire logic signed [8:0] i_temp_c, // nine bits so 130 C fits
    input wire pol_pkg::volt_t i_vout,
    input wire pol_pkg::volt_t i_setpoint,
    input wire pol_pkg::volt_t i_vref,
    input wire pol_pkg::volt_t i_prebias,
    input wire logic [7:0] i_iout_pct,
    input wire logic [7:0] i_uv_pct,
    input wire logic i_pgh_sel,
    input wire logic i_pgl_sel,
    input wire logic [7:0] i_pg_delay_ms,
    input wire logic i_pg_at_cmd,
    input wire logic i_track_dis,
    input wire logic [3:0] i_fault_latch,
    input wire logic i_on_cmd,
    input wire logic i_ramp_done,
    input wire logic i_ramp_falling,
    input wire logic i_pg_pin,
    output logic o_pg_oe,
    output logic o_switch_en,
    output logic o_fast_off,
    output logic o_seq_off,
    output logic [2:0] o_droop_select
);
    import pol_pkg::*;
    // every check below runs on the one control clock
    default clocking chk_clk @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);

    // ---------------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------------
    // percentage of setpoint; 13 bits since 110 percent can pass full scale
    function automatic logic [12:0] pct_of(input volt_t sp,
                                          input logic [7:0] pct);
        logic [19:0] prod;
        prod = 20'(sp) * 20'(pct);
        return 13'(prod / 20'd100);
    endfunction

    // limit code to percent of rated current; saturates above 0xB
    function automatic logic [7:0] limit_pct(input logic [3:0] code);
        logic [3:0] c;
        c = (code > `CL_MAX) ? `CL_MAX : code;
        unique case (c)
            4'h0: return 8'd37;
            4'h1: return 8'd47;
            4'h2: return 8'd57;
            4'h3: return 8'd66;
            4'h4: return 8'd75;
            4'h5: return 8'd84;
            4'h6: return 8'd94;
            4'h7: return 8'd103;
            4'h8: return 8'd112;
            4'h9: return 8'd121;
            4'hA: return 8'd131;
            default: return 8'd140;
        endcase
    endfunction

    // ---------------------------------------------------------------------
    // state
    // ---------------------------------------------------------------------
    pol_state_e state_reg, state_next;
    logic [7:0] cls_reg, cls_next;
    logic [3:0] flag_reg, flag_next; // tr, ot, oc, uv; 1 = active
    logic tw_reg, tw_next;
    logic pgw_reg, pgw_next;
    logic pg_rel_reg, pg_rel_next;
    logic on_d_reg;
    logic retry_start_reg, retry_start_next;
    logic pgd_start_reg, pgd_start_next;
    logic [7:0] rdata_next;
    logic pg_oe_next, sw_next, fast_next, seq_next;
    logic retry_busy, retry_done, pgd_busy, pgd_done;
    logic [12:0] pgh_lim, pgl_lim, uv_lim, trk_err;
    logic [8:0] oc_lim;
    logic oc_cond, tr_cond, uv_cond, ot_cond, win_bad, ext_low, powered;
    logic [3:0] hit, clr_w1, clr_auto;
    logic [7:0] st_val;
    logic [7:0] pg_dly;

    // ---------------------------------------------------------------------
    // timers: power-good release delay and restart hold-off
    // ---------------------------------------------------------------------
    assign pg_dly = (i_pg_delay_ms > `PG_DLY_MAX_MS) ? `PG_DLY_MAX_MS
                                                     : i_pg_delay_ms;

    ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_pg_delay (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_start(pgd_start_reg),
        .i_ms(pg_dly),
        .o_busy(pgd_busy),
        .o_done(pgd_done)
    );

    ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_retry (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_start(retry_start_reg),
        .i_ms(`RETRY_MS),
        .o_busy(retry_busy),
        .o_done(retry_done)
    );

    // ---------------------------------------------------------------------
    // comparisons on this cycle's samples
    // ---------------------------------------------------------------------
    always_comb begin
        pgh_lim = pct_of(i_setpoint, i_pgh_sel ? `PGH_HI_PCT
                                               : `PGH_LO_PCT);
        pgl_lim = pct_of(i_setpoint, i_pgl_sel ? `PGL_HI_PCT
                                               : `PGL_LO_PCT);
        uv_lim = pct_of(i_setpoint, i_uv_pct);
        // copper drift: widen the limit a quarter percent per degree hot
        oc_lim = 9'(limit_pct(cls_reg[3:0]));
        if (cls_reg[`CLS_TCE_BIT] && i_temp_c > `TCOMP_REF_C) begin
            oc_lim = oc_lim + 9'((i_temp_c - `TCOMP_REF_C) >>> 2);
        end
        trk_err = (i_vout > i_vref) ? 13'(i_vout - i_vref)
                                    : 13'(i_vref - i_vout);
        powered = state_reg != ST_OFF && state_reg != ST_HOLDOFF;
        oc_cond = powered && i_vout > i_prebias
                  && 9'(i_iout_pct) >= oc_lim;
        tr_cond = state_reg == ST_RAMP_UP && !i_track_dis
                  && trk_err > 13'(`TRACK_LSB);
        uv_cond = state_reg == ST_STEADY && 13'(i_vout) < uv_lim
                  && !oc_cond;
        ot_cond = i_temp_c > `OT_SET_C;
        // window limits follow the live setpoint, margining included
        win_bad = 13'(i_vout) > pgh_lim || 13'(i_vout) < pgl_lim;
        ext_low = !i_pg_pin && !o_pg_oe;
        hit = {tr_cond, ot_cond && state_reg != ST_OFF, oc_cond, uv_cond};
    end

    // ---------------------------------------------------------------------
    // flags, power state and power-good
    // ---------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        retry_start_next = 1'b0;
        pgd_start_next = 1'b0;
        fast_next = 1'b0;
        // warning hysteresis between the two temperature levels
        tw_next = tw_reg;
        if (i_temp_c > `TW_SET_C) begin
            tw_next = 1'b1;
        end else if (i_temp_c < `TW_CLR_C) begin
            tw_next = 1'b0;
        end
        clr_w1 = 4'h0;
        if (i_reg_wr && i_reg_addr == `ADDR_ST) begin
            clr_w1 = i_reg_wdata[`ST_TR_BIT:`ST_UV_BIT];
        end
        clr_auto = 4'h0;
        if (state_reg == ST_OFF && retry_done) begin
            clr_auto = ~i_fault_latch & ~hit;
        end
        if (!i_fault_latch[2] && i_temp_c < `TW_SET_C) begin
            clr_auto[2] = 1'b1;
        end
        if (on_d_reg && !i_on_cmd) begin
            clr_auto = 4'hF;
        end
        // a new event beats a clear in the same cycle
        flag_next = (flag_reg & ~clr_w1 & ~clr_auto) | hit;
        unique case (state_reg)
            ST_OFF: begin
                if (i_on_cmd && flag_reg == 4'h0 && !retry_busy) begin
                    state_next = ST_HOLDOFF;
                end
            end
            ST_HOLDOFF: begin
                if (!i_on_cmd) begin
                    state_next = ST_OFF;
                end else if (i_vref > i_prebias) begin
                    state_next = ST_RAMP_UP;
                end
            end
            ST_RAMP_UP: begin
                if (i_ramp_done) begin
                    state_next = ST_STEADY;
                    pgd_start_next = 1'b1;
                end
            end
            ST_STEADY: begin
                if (!i_on_cmd) begin
                    state_next = ST_RAMP_DOWN;
                end
            end
            ST_RAMP_DOWN: begin
                if (i_ramp_done) begin
                    state_next = ST_OFF;
                end
            end
        endcase
        // every fault turns off; warnings never reach this point
        if ((hit[3] || hit[1]) && state_reg != ST_OFF) begin
            state_next = ST_OFF;
            fast_next = 1'b1;
        end else if ((hit[2] || hit[0]) && powered
                     && state_reg != ST_RAMP_DOWN) begin
            state_next = ST_RAMP_DOWN;
        end else if (hit[2] && state_reg == ST_HOLDOFF) begin
            state_next = ST_OFF;
        end
        if ((hit & ~flag_reg) != 4'h0) begin
            retry_start_next = 1'b1;
        end
        // release after the steady-state delay; drop per turn-off option
        pg_rel_next = pg_rel_reg;
        if (!pg_rel_reg) begin
            pg_rel_next = state_reg == ST_STEADY && pgd_done
                          && !pgd_start_reg && !pgd_busy;
        end
        if (state_next != ST_STEADY && state_next != ST_RAMP_DOWN) begin
            pg_rel_next = 1'b0;
        end
        if ((i_pg_at_cmd && !i_on_cmd)
            || (!i_pg_at_cmd && i_ramp_falling)) begin
            pg_rel_next = 1'b0;
        end
        pgw_next = pg_rel_reg && state_reg == ST_STEADY
                   && (win_bad || ext_low);
        // an external pull alone is only reported: driving as well would
        // hide the pull on the next sample and make the warning oscillate
        pg_oe_next = !pg_rel_next || (pgw_next && win_bad);
        sw_next = state_next == ST_RAMP_UP || state_next == ST_STEADY
                  || state_next == ST_RAMP_DOWN;
        seq_next = state_next == ST_RAMP_DOWN;
    end

    // ---------------------------------------------------------------------
    // register port: write limit register, read status or limit
    // ---------------------------------------------------------------------
    always_comb begin
        st_val = {~tw_reg, ~pgw_reg, ~flag_reg, 1'b1, 1'b1};
        cls_next = cls_reg;
        if (i_reg_wr && i_reg_addr == `ADDR_CLS) begin
            cls_next = i_reg_wdata;
        end
        rdata_next = o_reg_rdata;
        if (i_reg_rd) begin
            unique case (i_reg_addr)
                `ADDR_CLS: rdata_next = cls_reg;
                `ADDR_ST: rdata_next = st_val;
                default: rdata_next = 8'h00;
            endcase
        end
    end

    // everything latches on the clock edge
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_reg <= ST_OFF;
            cls_reg <= `CLS_RST;
            flag_reg <= 4'h0;
            tw_reg <= 1'b0;
            pgw_reg <= 1'b0;
            pg_rel_reg <= 1'b0;
            on_d_reg <= 1'b0;
            retry_start_reg <= 1'b0;
            pgd_start_reg <= 1'b0;
            o_reg_rdata <= 8'h00;
            o_pg_oe <= 1'b1;
            o_switch_en <= 1'b0;
            o_fast_off <= 1'b0;
            o_seq_off <= 1'b0;
            o_droop_select <= 3'h0;
        end else begin
            state_reg <= state_next;
            cls_reg <= cls_next;
            flag_reg <= flag_next;
            tw_reg <= tw_next;
            pgw_reg <= pgw_next;
            pg_rel_reg <= pg_rel_next;
            on_d_reg <= i_on_cmd;
            retry_start_reg <= retry_start_next;
            pgd_start_reg <= pgd_start_next;
            o_reg_rdata <= rdata_next;
            o_pg_oe <= pg_oe_next;
            o_switch_en <= sw_next;
            o_fast_off <= fast_next;
            o_seq_off <= seq_next;
            o_droop_select <= cls_next[`CLS_DROOP_HI:`CLS_DROOP_LO];
        end
    end

    // ---------------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------------
    a_tw_set: assert property (
        i_temp_c > `TW_SET_C |=> tw_reg)
        else $error("temperature warning not raised");
    a_tw_hyst: assert property (
        tw_reg && i_temp_c >= `TW_CLR_C |=> tw_reg)
        else $error("temperature warning cleared too early");
    a_oc_fast_off: assert property (
        oc_cond |=> o_fast_off && !o_switch_en && flag_reg[1])
        else $error("overcurrent did not force fast off");
    a_tr_fast_off: assert property (
        tr_cond |=> o_fast_off && state_reg == ST_OFF && st_val[5] == 1'b0)
        else $error("tracking fault not handled");
    a_uv_ramp_down: assert property (
        uv_cond |=> state_reg == ST_RAMP_DOWN && o_seq_off && flag_reg[0])
        else $error("undervoltage did not start ramp-down");
    a_holdoff_gate: assert property (
        state_reg == ST_HOLDOFF && i_vref <= i_prebias |=> !o_switch_en)
        else $error("switching before reference passed pre-bias");
    a_set_wins_clear: assert property (
        i_reg_wr && i_reg_addr == `ADDR_ST && hit[2] |=> flag_reg[2])
        else $error("fault lost against status clear");
    a_pg_window_low: assert property (
        pg_rel_reg && state_reg == ST_STEADY && win_bad && i_on_cmd
        && !i_ramp_falling |=> o_pg_oe && !st_val[6])
        else $error("power good not pulled low outside window");
    a_retry_gate: assert property (
        state_reg == ST_OFF && retry_busy |=> state_reg == ST_OFF)
        else $error("restart before the retry interval");
    a_warn_no_off: assert property (
        state_reg == ST_STEADY && i_on_cmd && hit == 4'h0 |=>
        state_reg == ST_STEADY)
        else $error("warning turned the output off");
    c_uv_trip: cover property (uv_cond ##1 state_reg == ST_RAMP_DOWN);
    c_oc_trip: cover property (oc_cond ##1 o_fast_off);
    c_ot_trip: cover property (ot_cond && powered ##1 o_seq_off);
    c_pg_release: cover property (o_pg_oe ##1 !o_pg_oe);
endmodule // pol_protection_manager

// >>> verilog/pol_cfg.svh
`ifndef POL_CFG_SVH
`define POL_CFG_SVH
// What this block does
// - temperature above 120 C raises the temperature warning and its bit
// - temperature warning clears only once temperature drops below 117 C
// - power-good pin driven low outside a 105/110 and 90/95 percent window
// - power-good checked only in steady state, released after 0-150 ms
// - power-good warning holds pin low and bit 0; clears back in window
// - external low on the power-good pin starts the power-good warning
// - option drops power-good at turn-off command or at ramp-down start
// - power-good stays checked while margining, window follows setpoint
// - undervoltage and power-good limits are percentages of the setpoint
// - above pre-bias, current at limit flags overcurrent, both switches off
// - 4-bit limit code, 0x0 is 37 percent, codes above 0xB act as 0xB
// - bits 7:5 of the limit register select droop, default zero
// - a register bit enables limit temperature compensation, default on
// - steady-state undervoltage without overcurrent flags and ramps down
// - above 130 C flag over-temperature and ramp down, whenever powered
// - non-latching over-temperature restarts once below 120 C
// - while ramping up, more than 250 mV tracking error trips fast off
// - a controller-written bit disables tracking protection
// - warnings only signal; every fault turns the output off
// - pre-biased output: no switching until ramp reference passes it
// - status: bit7 warn, 6 pg, 5 trk, 4 ot, 3 oc, 2 uv, 1 ov; 0 active
// - writing 1 to a fault or error status bit clears it
// - non-latching retries every 130 ms; latching stays off

// ---------------------------------------------------------------------
// register map
// ---------------------------------------------------------------------
`define ADDR_CLS 8'h08
`define ADDR_ST 8'h16
`define CLS_RST 8'h1B
`define CLS_DROOP_HI 7
`define CLS_DROOP_LO 5
`define CLS_TCE_BIT 4
`define CL_MAX 4'hB
`define ST_TW_BIT 7
`define ST_PG_BIT 6
`define ST_TR_BIT 5
`define ST_UV_BIT 2
`define ST_OV_BIT 1

// ---------------------------------------------------------------------
// thresholds and timing
// ---------------------------------------------------------------------
`define TW_SET_C 9'sd120
`define TW_CLR_C 9'sd117
`define OT_SET_C 9'sd130
`define TCOMP_REF_C 9'sd25
`define PGH_LO_PCT 8'd105
`define PGH_HI_PCT 8'd110
`define PGL_LO_PCT 8'd90
`define PGL_HI_PCT 8'd95
`define PG_DLY_MAX_MS 8'd150
`define RETRY_MS 8'd130
`define CLK_HZ 20000000
`define CYC_PER_MS (`CLK_HZ / 1000)
`define TRACK_MV 250
`define VLSB_UV 2500
`define TRACK_LSB (`TRACK_MV * 1000 / `VLSB_UV)
`endif

// >>> verilog/pol_pkg.sv
package pol_pkg;
    // converter power state
    typedef enum logic [2:0] {
        ST_OFF = 3'b000,
        ST_HOLDOFF = 3'b001,
        ST_RAMP_UP = 3'b010,
        ST_STEADY = 3'b011,
        ST_RAMP_DOWN = 3'b100
    } pol_state_e;
    typedef logic [11:0] volt_t;
endpackage

// >>> verilog/ms_timer.sv
`timescale 1ns/10ps
// millisecond one-shot: done rises i_ms milliseconds after a start pulse
module ms_timer #(
    parameter int unsigned CYC_PER_MS = 20000
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_start,
    input wire logic [7:0] i_ms,
    output logic o_busy,
    output logic o_done
);
    logic [7:0] ms_reg, ms_next;
    logic [23:0] sub_reg, sub_next;
    logic busy_next, done_next;

    // start reloads; otherwise count cycles, then milliseconds
    always_comb begin
        ms_next = ms_reg;
        sub_next = sub_reg;
        busy_next = o_busy;
        done_next = o_done;
        if (i_start) begin
            ms_next = i_ms;
            sub_next = 24'h000000;
            busy_next = 1'b1;
            done_next = 1'b0;
        end else if (o_busy) begin
            if (ms_reg == 8'h00) begin
                busy_next = 1'b0;
                done_next = 1'b1;
            end else if (sub_reg == 24'(CYC_PER_MS - 1)) begin
                sub_next = 24'h000000;
                ms_next = ms_reg - 8'h01;
            end else begin
                sub_next = sub_reg + 24'h000001;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ms_reg <= 8'h00;
            sub_reg <= 24'h000000;
            o_busy <= 1'b0;
            o_done <= 1'b0;
        end else begin
            ms_reg <= ms_next;
            sub_reg <= sub_next;
            o_busy <= busy_next;
            o_done <= done_next;
        end
    end
endmodule // ms_timer

// >>> testbench/pol_host_model.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// power manager stand-in: register master on the host bus
// ---------------------------------------------------------------
module pol_host_model (
    input wire logic i_clk,
    output logic [7:0] o_addr,
    output logic o_wr,
    output logic o_rd,
    output logic [7:0] o_wdata,
    input wire logic [7:0] i_rdata
);
    initial begin
        o_addr = 8'h00;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_wdata = 8'h00;
    end

    // one strobe per access; released lines show junk, not the old value
    task automatic access(input logic w, input logic [7:0] a,
                          input logic [7:0] d, output logic [7:0] q);
        @(posedge i_clk);
        #2;
        o_addr = a;
        o_wdata = d;
        o_wr = w;
        o_rd = !w;
        @(posedge i_clk);
        #2;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = ~a;
        o_wdata = ~d;
        q = i_rdata;
    endtask

    // read-modify-write so the droop bits survive a limit change
    task automatic set_limit(input logic [3:0] code, output logic [7:0] q);
        access(1'b0, 8'h08, 8'h00, q);
        access(1'b1, 8'h08, {q[7:4], code}, q);
    endtask

    // write ones over every fault bit to drop latched faults
    task automatic clear_faults(output logic [7:0] q);
        access(1'b1, 8'h16, 8'h3C, q);
    endtask
endmodule // pol_host_model

// >>> testbench/pol_protection_manager_tb_top.sv
`timescale 1ns/10ps
module pol_protection_manager_tb_top;
    import pol_pkg::*;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic [7:0] reg_addr, reg_wdata, rdata, q, r;
    logic reg_wr, reg_rd, pg_oe, sw_en, fast_off, seq_off;
    logic signed [8:0] temp_c = 9'sd25;
    volt_t vout = 12'h000, setpt = 12'h190, vref = 12'h000, prebias = 12'h050;
    logic [7:0] iout = 8'h00;
    logic pgh = 1'b0, pgl = 1'b0, pg_at_cmd = 1'b0, track_dis = 1'b0;
    logic on_cmd = 1'b0, ramp_done = 1'b0, ramp_fall = 1'b0, ext_low = 1'b0;
    logic [2:0] droop;
    logic [3:0] latch = 4'hF;
    logic [31:0] rng = 32'h93E0;
    int err_count = 0;
    int num_checks = 0;
    // open-collector wire with pull-up: low if anyone pulls
    wire logic pg_pin = !(pg_oe || ext_low);

    always #25 i_clk = ~i_clk;

    pol_host_model host (.i_clk(i_clk), .o_addr(reg_addr), .o_wr(reg_wr),
        .o_rd(reg_rd), .o_wdata(reg_wdata), .i_rdata(rdata));

    pol_protection_manager #(.CYC_PER_MS(4)) dut (.i_clk(i_clk),
        .i_sys_rst(i_sys_rst), .i_reg_addr(reg_addr), .i_reg_wr(reg_wr),
        .i_reg_rd(reg_rd), .i_reg_wdata(reg_wdata), .o_reg_rdata(rdata),
        .i_temp_c(temp_c), .i_vout(vout), .i_setpoint(setpt),
        .i_vref(vref), .i_prebias(prebias), .i_iout_pct(iout),
        .i_uv_pct(8'h32), .i_pgh_sel(pgh), .i_pgl_sel(pgl),
        .i_pg_delay_ms(8'h01), .i_pg_at_cmd(pg_at_cmd),
        .i_track_dis(track_dis), .i_fault_latch(latch), .i_on_cmd(on_cmd),
        .i_ramp_done(ramp_done), .i_ramp_falling(ramp_fall),
        .i_pg_pin(pg_pin), .o_pg_oe(pg_oe), .o_switch_en(sw_en),
        .o_fast_off(fast_off), .o_seq_off(seq_off), .o_droop_select(droop));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    // volts at a percentage of the present setpoint
    function automatic volt_t pct(input int p);
        return volt_t'(setpt * p / 100);
    endfunction

    task automatic tick();
        @(posedge i_clk);
        #2;
    endtask

    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // bounded wait on one output; 0 sw, 1 fast, 2 seq, 3 pg
    task automatic await(input int sel, input logic lvl, input string nm);
        logic s;
        for (int n = 0; n < 200; n++) begin
            tick();
            s = sel == 0 ? sw_en : sel == 1 ? fast_off : sel == 2 ?
                seq_off : pg_oe;
            if (s === lvl) break;
        end
        chk(nm, lvl, s);
    endtask

    task automatic stat(input int b, input logic e, input string nm);
        repeat (3) tick();
        host.access(1'b0, 8'h16, 8'h00, q);
        chk(nm, e, q[b]);
    endtask

    // ramp reference climbs past the pre-bias before switching starts
    task automatic power_up(input logic steady);
        vref = 12'h000;
        vout = prebias;
        on_cmd = 1'b1;
        repeat (4) tick();
        chk("held off", 8'h00, sw_en);
        vref = 12'h060;
        await(0, 1'b1, "switch on");
        vref = setpt;
        vout = setpt;
        chk("pg in ramp", 8'h01, pg_oe);
        ramp_done = steady;
        tick();
        ramp_done = 1'b0;
    endtask

    // the retry timer must run out before the next start is allowed
    task automatic power_down();
        on_cmd = 1'b0;
        vout = 12'h000;
        iout = 8'h00;
        ramp_done = 1'b1;
        tick();
        ramp_done = 1'b0;
        ramp_fall = 1'b0;
        repeat (530) tick();
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (2) tick();
        chk("pg_oe rst", 8'h01, pg_oe);
        chk("droop rst", 8'h00, droop);
        i_sys_rst = 1'b0;
        host.access(1'b0, 8'h16, 8'h00, q);
        chk("status rst", 8'hFF, q);
        host.access(1'b0, 8'h08, 8'h00, q);
        chk("limit rst", 8'h1B, q);
        host.access(1'b0, 8'h3C, 8'h00, q);
        chk("unmapped", 8'h00, q);
        for (int k = 0; k < 6; k++) begin
            rng = xs(rng);
            r = rng[7:0];
            host.access(1'b1, 8'h08, r, q);
            chk("droop", {5'h00, r[7:5]}, droop);
            host.set_limit(4'hB, q);
            host.access(1'b0, 8'h08, 8'h00, q);
            chk("limit rmw", {r[7:4], 4'hB}, q);
        end
        host.access(1'b1, 8'h08, 8'h1B, q);
        $display("test registers done");
        temp_c = 9'sd120;
        stat(7, 1'b1, "warn at 120");
        rng = xs(rng);
        temp_c = 9'sd121 + 9'(rng[7:0] % 9);
        stat(7, 1'b0, "warn set");
        temp_c = 9'sd117;
        stat(7, 1'b0, "warn hyst");
        temp_c = 9'sd116;
        stat(7, 1'b1, "warn clear");
        temp_c = 9'sd25;
        $display("test temperature done");
        power_up(1'b1);
        await(3, 1'b0, "pg release");
        for (int s = 0; s < 4; s++) begin
            pgh = s[0];
            pgl = s[1];
            vout = pct(pgh ? 111 : 106);
            await(3, 1'b1, "pg high");
            stat(6, 1'b0, "pg bit");
            vout = pct(pgl ? 94 : 89);
            await(3, 1'b1, "pg low");
            vout = pct(pgl ? 96 : 91);
            await(3, 1'b0, "pg back");
        end
        chk("warn keeps on", 8'h01, sw_en);
        setpt = 12'h1F4;
        await(3, 1'b1, "pg margin");
        setpt = 12'h190;
        await(3, 1'b0, "pg margin back");
        ext_low = 1'b1;
        stat(6, 1'b0, "pg external");
        ext_low = 1'b0;
        on_cmd = 1'b0;
        repeat (4) tick();
        chk("pg waits ramp", 8'h00, pg_oe);
        ramp_fall = 1'b1;
        await(3, 1'b1, "pg at ramp");
        power_down();
        pg_at_cmd = 1'b1;
        power_up(1'b1);
        await(3, 1'b0, "pg release 2");
        on_cmd = 1'b0;
        tick();
        await(3, 1'b1, "pg at cmd");
        power_down();
        $display("test power good done");
        power_up(1'b1);
        iout = 8'd139;
        repeat (5) tick();
        chk("below limit", 8'h01, sw_en);
        iout = 8'd140;
        await(1, 1'b1, "oc fast off");
        tick();
        chk("oc switch", 8'h00, sw_en);
        iout = 8'h00;
        stat(3, 1'b0, "oc bit");
        host.clear_faults(q);
        stat(3, 1'b1, "oc cleared");
        power_down();
        power_up(1'b1);
        vout = pct(49);
        await(2, 1'b1, "uv seq off");
        stat(2, 1'b0, "uv bit");
        power_down();
        // over-temperature: a clear while still hot must not drop the flag
        power_up(1'b1);
        temp_c = 9'sd131;
        await(2, 1'b1, "ot seq off");
        host.clear_faults(q);
        stat(4, 1'b0, "ot set wins");
        latch = 4'hB;
        temp_c = 9'sd119;
        stat(4, 1'b1, "ot auto clear");
        temp_c = 9'sd25;
        power_down();
        $display("test oc uv done");
        track_dis = 1'b1;
        power_up(1'b0);
        vout = vref + 12'd101;
        repeat (5) tick();
        chk("track off", 8'h01, sw_en);
        track_dis = 1'b0;
        vout = vref + 12'd100;
        repeat (5) tick();
        chk("track edge", 8'h01, sw_en);
        vout = vref + 12'd101;
        await(1, 1'b1, "track trip");
        stat(5, 1'b0, "tr bit");
        power_down();
        $display("test tracking done");
        close_out();
    end

    // watchdog sized well past the expected few thousand cycles
    initial begin
        #(20000 * 50);
        err_count++;
        close_out();
    end
endmodule // pol_protection_manager_tb_top
